//--- sim/oag_core_monitor.sv
// Purpose: Port-level checks for the operand address sequencer.
// Assumes: One clock, async active-low reset, word memory port.
// Notes: Bound to oag_core after the module.
`timescale 1ns/1ps
module oag_core_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:1] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // Architectural state
  input wire logic [15:0] pc_out,
  input wire logic [15:0] wp_out,
  input wire logic [15:0] st_out
);
  // Everything here lives in the one core clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // A pending word request holds still until its ack
  AST_REQ_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
    else $error("Request changed before ack");
  // An acked request drops, leaving an idle cycle
  AST_REQ_GAP: assert property (
    mem_req && mem_ack |=> !mem_req && !mem_we)
    else $error("No idle cycle after ack");
  // Write strobe never appears without a request
  AST_WE_WITH_REQ: assert property (
    mem_we |-> mem_req)
    else $error("Write strobe without request");
  // A word read at the program counter moves it on by two
  AST_FETCH_STEP: assert property (
    mem_req && mem_ack && !mem_we && {mem_addr, 1'b0} == pc_out
    |=> pc_out == $past(pc_out) + 16'h0002)
    else $error("Program counter did not step by two");
  // Instructions sit on even addresses only
  AST_PC_EVEN: assert property (
    $rose(mem_req) |-> pc_out[0] == 1'b0)
    else $error("Odd program counter");
  // A new workspace appears only right after a save write
  AST_WP_SWITCH: assert property (
    $changed(wp_out) |-> $past(mem_req && mem_we && mem_ack))
    else $error("Workspace changed without a save write");
  // Program counter holds still while a write waits for its ack
  AST_PC_QUIET: assert property (
    mem_req && mem_we && !mem_ack |=> $stable(pc_out))
    else $error("Program counter moved during a write");
  // Workspace pointer is steady while an access waits
  AST_WP_QUIET: assert property (
    mem_req && !mem_ack ##1 mem_req |-> $stable(wp_out))
    else $error("Workspace moved during an access");
  // After reset the first fetch comes from word zero
  AST_RESET_FETCH: assert property (
    $rose(rst_n) |-> ##[1:3] mem_req && mem_addr == 15'h0000)
    else $error("No fetch from zero after reset");

  // Main scenarios seen
  COV_WRITE: cover property (mem_req && mem_we && mem_ack);
  COV_SWITCH: cover property ($changed(wp_out));
  COV_SLOW: cover property (mem_req && !mem_ack ##1 mem_ack);
endmodule // oag_core_monitor

bind oag_core oag_core_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .pc_out(pc_out), .wp_out(wp_out), .st_out(st_out));

//--- sim/oag_mem_model.sv
// Purpose: Word memory answering the sequencer's requests.
// Assumes: Requests hold until ack; ack is one cycle.
// Notes: Idle read data is the inverse of the last word, never stale.
`timescale 1ns/1ps
module oag_mem_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Word port from the device
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:1] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // Wait cycles before each ack
  input wire logic [1:0] lat
);
  logic [15:0] ram [0:32767]; // Indexed by word address
  logic [1:0] wait_r; // Cycles the current request has waited
  logic [15:0] last_r; // Last word handed out
  // At least rather than equal, so a latency change never hangs
  assign mem_ack = mem_req && (wait_r >= lat);
  assign mem_rdata = mem_ack ? ram[mem_addr] : ~last_r;
  // Count waits, store writes, remember read data
  // Plain always: the bench also preloads the array before reset ends
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 2'h0;
      last_r <= 16'h0000;
    end else if (mem_ack) begin
      wait_r <= 2'h0;
      last_r <= mem_rdata;
      if (mem_we) begin
        ram[mem_addr] <= mem_wdata;
      end
    end else if (mem_req) begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule // oag_mem_model

//--- sim/tb_operand_address_generation.sv
// Purpose: Runs a small program through the address sequencer.
// Assumes: Program is preloaded; memory answers every request.
// Notes: Each task waits for fetches at given addresses, then reads memory.
`timescale 1ns/1ps
module tb_operand_address_generation import oag_pkg::*;;
  logic core_clk, rst_n, mem_req, mem_we, mem_ack;
  logic [15:1] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, pc_out, wp_out, st_out;
  logic [1:0] lat; // Memory wait cycles
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  oag_core uut (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .pc_out(pc_out),
    .wp_out(wp_out), .st_out(st_out));
  oag_mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .lat(lat));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Report and stop
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, the program needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [15:0] rd(input logic [15:0] a);
    return u_mem.ram[a[15:1]];
  endfunction

  task automatic put(input logic [15:0] a, input logic [15:0] v);
    u_mem.ram[a[15:1]] = v;
  endtask

  // Wait until an access of address a is on the port; it must be a fetch
  task automatic run_to(input logic [15:0] a);
    do begin
      @(posedge core_clk);
      #1;
    end while (!(mem_req === 1'b1 && mem_addr === a[15:1]));
    check(pc_out, a);
  endtask

  task automatic t_switch();
    run_to(16'h0100);
    check(wp_out, 16'h0200);
    check(rd(16'h0200 + OAG_OFS_OLD_WP), 16'h0000);
    check(rd(16'h0200 + OAG_OFS_OLD_PC), 16'h0004);
    $display("switch call done");
  endtask

  task automatic t_moves();
    lat = 2'h2; // Slow memory for these accesses
    run_to(16'h0104);
    check(rd(16'h0202), 16'h0300);
    run_to(16'h0106);
    lat = 2'h0;
    check(rd(16'h0204), 16'hBEEF);
    check(rd(16'h0202), 16'h0302);
    run_to(16'h010E);
    check(rd(16'h0400), 16'h12AA);
    check(rd(16'h0202), 16'h0303);
    check(rd(16'h0402), 16'hBE55);
    run_to(16'h0118);
    check(rd(16'h0604), 16'h7777);
    $display("moves done");
  endtask

  task automatic t_call();
    run_to(16'h0140);
    check(rd(16'h0200 + OAG_OFS_LINK), 16'h011C);
    run_to(16'h011C);
    run_to(16'h0020);
    run_to(16'h0120);
    run_to(16'h0022);
    $display("call and jumps done");
  endtask

  task automatic t_trap();
    run_to(16'h0180);
    check(wp_out, 16'h0800);
    check(rd(16'h0800 + OAG_OFS_LINK), 16'h0700);
    check(rd(16'h0800 + OAG_OFS_OLD_WP), 16'h0200);
    check(rd(16'h0800 + OAG_OFS_OLD_PC), 16'h0026);
    check(rd(16'h0800 + OAG_OFS_OLD_ST), OAG_RESET_ST);
    // A zero word moved from memory into R1 of the new workspace
    run_to(16'h0184);
    check(rd(16'h0802), 16'h0000);
    check(st_out, 16'h0001 << OAG_ST_ZERO_BIT);
    $display("trap done");
  endtask

  initial begin
    rst_n = 1'b0;
    lat = 2'h0;
    put(16'h0000, 16'h0420); // Switch call through 0x0080
    put(16'h0002, 16'h0080);
    put(16'h0080, 16'h0200);
    put(16'h0082, 16'h0100);
    put(16'h0100, 16'h0201); // Load R1 with 0x0300
    put(16'h0102, 16'h0300);
    put(16'h0104, 16'hC0B1); // Word move R1 indirect inc to R2
    put(16'h0106, 16'hD831); // Byte move R1 indirect inc to 0x0400
    put(16'h0108, 16'h0400);
    put(16'h010A, 16'hD802); // Byte move R2 to 0x0402
    put(16'h010C, 16'h0402);
    put(16'h010E, 16'h0203); // Load R3 with 0x0600
    put(16'h0110, 16'h0600);
    put(16'h0112, 16'hC8E0); // Move 0x0500 to 4 plus R3
    put(16'h0114, 16'h0500);
    put(16'h0116, 16'h0004);
    put(16'h0118, 16'h06A0); // Call with link to 0x0140
    put(16'h011A, 16'h0140);
    put(16'h0140, 16'h045B); // Branch through R11
    put(16'h011C, 16'h1081); // Back by 127 words
    put(16'h0020, 16'h107F); // Furthest forward
    put(16'h0120, 16'h1080); // Most negative offset
    put(16'h0022, 16'h2FE0); // Trap 15 with source 0x0700
    put(16'h0024, 16'h0700);
    put(16'h007C, 16'h0800);
    put(16'h007E, 16'h0180);
    put(16'h0180, 16'hC060); // Word move a zero word to R1
    put(16'h0182, 16'h0900);
    put(16'h0184, 16'h10FF); // Park in place
    put(16'h0900, 16'h0000);
    put(16'h0300, 16'hBEEF);
    put(16'h0302, 16'h1234);
    put(16'h0400, 16'hAAAA);
    put(16'h0402, 16'h5555);
    put(16'h0500, 16'h7777);
    repeat (4) @(posedge core_clk);
    check(pc_out, OAG_RESET_PC);
    check(wp_out, OAG_RESET_WP);
    #1 rst_n = 1'b1;
    t_switch();
    t_moves();
    t_call();
    t_trap();
    close_out();
  end
endmodule // tb_operand_address_generation

//--- src/oag_core.sv
// Purpose: Instruction sequencer forming operand addresses and linkage.
// Assumes: Memory holds req until a one-cycle ack; word data only.
// Notes: Arithmetic beyond moves is not handled; unknown ops are skipped.
`timescale 1ns/1ps
module oag_core import oag_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Word memory port, no byte address bit
  output logic mem_req,
  output logic mem_we,
  output logic [15:1] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // Architectural state, for observation
  output logic [15:0] pc_out,
  output logic [15:0] wp_out,
  output logic [15:0] st_out
);

  // The only architectural registers; all general registers are memory
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] wp_r, wp_nxt;
  logic [15:0] st_r, st_nxt;
  // Scratch latches of the sequencer, not visible to programs
  logic [15:0] ir_r, ir_nxt;         // Current instruction word
  logic [15:0] ea_r, ea_nxt;         // Working / destination address
  logic [15:0] src_ea_r, src_ea_nxt; // Resolved source address
  logic [15:0] tmp_r, tmp_nxt;       // Source data
  logic [15:0] dtmp_r, dtmp_nxt;     // Old destination word for bytes
  logic [15:0] nwp_r, nwp_nxt;       // Incoming workspace pointer
  logic [15:0] npc_r, npc_nxt;       // Incoming program counter
  logic phase_r, phase_nxt;          // Low: source operand, high: dest
  oag_state_e state_r, state_nxt;
  // Memory request flops
  logic req_r, we_r;
  logic [15:1] addr_r;
  logic [15:0] wdata_r;

  // Instruction decode
  wire [3:0] op4 = ir_r[15:12];
  wire is_byte = (op4 == OAG_OP_BYTE_MOVE);
  wire is_move = (op4 == OAG_OP_WORD_MOVE) || is_byte;
  wire is_branch = (ir_r[15:6] == OAG_OP_BRANCH);
  wire is_link = (ir_r[15:6] == OAG_OP_CALL_WITH_LINK);
  wire is_wsc = (ir_r[15:6] == OAG_OP_WORKSPACE_SWITCH_CALL);
  wire is_trap = (ir_r[15:10] == OAG_OP_EXTENDED_OPERATION_TRAP);
  wire is_jump = (ir_r[15:8] == OAG_OP_RELATIVE_JUMP);
  wire is_li = (ir_r[15:4] == OAG_OP_LOAD_IMMEDIATE);
  wire is_single = is_branch || is_link || is_wsc || is_trap;

  // Field of the operand being resolved: destination in phase one
  wire [3:0] cur_reg = phase_r ? ir_r[9:6] : ir_r[3:0];
  wire [1:0] cur_mode = phase_r ? ir_r[11:10] : ir_r[5:4];
  // Register x sits at workspace plus two times x
  wire [15:0] reg_addr = wp_r + {11'h000, cur_reg, 1'b0};
  wire [15:0] inc_amt = is_byte ? OAG_BYTE_STEP : OAG_WORD_STEP;
  // Sign-extended displacement, doubled
  wire [15:0] jump_ofs = {{7{ir_r[7]}}, ir_r[7:0], 1'b0};
  // Vector source: resolved operand or trap table entry
  wire [15:0] trap_vec = OAG_TRAP_VEC_BASE + {10'h000, ir_r[9:6], 2'b00};
  wire [15:0] vec_base = is_trap ? trap_vec : src_ea_r;
  wire [15:0] vec_pc = vec_base + OAG_WORD_STEP;

  // Byte selection inside the processor; even address is the left byte
  wire [7:0] src_byte = src_ea_r[0] ? tmp_r[7:0] : tmp_r[15:8];
  wire [15:0] byte_merge = ea_r[0] ? {dtmp_r[15:8], src_byte}
                                   : {src_byte, dtmp_r[7:0]};
  wire [15:0] move_data = is_byte ? byte_merge : tmp_r;

  // State decode
  wire s_fetch = (state_r == OAG_FETCH);
  wire s_const = (state_r == OAG_CONST);
  wire s_rreg = (state_r == OAG_RREG);
  wire s_inc = (state_r == OAG_INC);
  wire s_rsrc = (state_r == OAG_RSRC);
  wire s_rdst = (state_r == OAG_RDST);
  wire s_wdst = (state_r == OAG_WDST);
  wire s_wlink = (state_r == OAG_WLINK);
  wire s_vwp = (state_r == OAG_VWP);
  wire s_vpc = (state_r == OAG_VPC);
  wire s_sv13 = (state_r == OAG_SV13);
  wire s_sv14 = (state_r == OAG_SV14);
  wire s_sv15 = (state_r == OAG_SV15);
  wire s_sv11 = (state_r == OAG_SV11);

  // States that own a memory access
  wire acc = s_fetch || s_const || s_rreg || s_inc || s_rsrc || s_rdst
             || s_wdst || s_wlink || s_vwp || s_vpc || s_sv13 || s_sv14
             || s_sv15 || s_sv11;
  wire acc_we = s_inc || s_wdst || s_wlink || s_sv13 || s_sv14
                || s_sv15 || s_sv11;
  // Access address per state; instruction stream always uses the PC
  wire [15:0] acc_addr =
      (s_fetch || s_const) ? pc_r :
      (s_rreg || s_inc) ? reg_addr :
      s_rsrc ? src_ea_r :
      (s_rdst || s_wdst) ? ea_r :
      s_wlink ? wp_r + OAG_OFS_LINK :
      s_vwp ? vec_base :
      s_vpc ? vec_pc :
      s_sv13 ? nwp_r + OAG_OFS_OLD_WP :
      s_sv14 ? nwp_r + OAG_OFS_OLD_PC :
      s_sv15 ? nwp_r + OAG_OFS_OLD_ST :
      nwp_r + OAG_OFS_LINK;
  wire [15:0] acc_wdata =
      s_inc ? ea_r + inc_amt :
      s_wdst ? move_data :
      s_wlink ? pc_r :
      s_sv13 ? wp_r :
      s_sv14 ? pc_r :
      s_sv15 ? st_r :
      src_ea_r;
  // Non-access states advance every cycle; others wait for the ack
  wire step = acc ? (req_r && mem_ack) : 1'b1;
  wire [15:0] rd = mem_rdata;

  // Sequencer next-state and datapath
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    wp_nxt = wp_r;
    st_nxt = st_r;
    ir_nxt = ir_r;
    ea_nxt = ea_r;
    src_ea_nxt = src_ea_r;
    tmp_nxt = tmp_r;
    dtmp_nxt = dtmp_r;
    nwp_nxt = nwp_r;
    npc_nxt = npc_r;
    phase_nxt = phase_r;
    if (step) begin
      case (state_r)
        OAG_FETCH: begin
          // Opcode word, PC moves to the next word
          ir_nxt = rd;
          pc_nxt = pc_r + OAG_WORD_STEP;
          state_nxt = OAG_DECODE;
        end
        OAG_DECODE: begin
          phase_nxt = 1'b0;
          if (is_move || is_single) begin
            state_nxt = OAG_RES;
          end else if (is_jump) begin
            // PC already points at the next sequential instruction
            pc_nxt = pc_r + jump_ofs;
            state_nxt = OAG_FETCH;
          end else if (is_li) begin
            state_nxt = OAG_CONST;
          end else begin
            // Unknown opcode is skipped
            state_nxt = OAG_FETCH;
          end
        end
        OAG_RES: begin
          // Register mode needs no access; only indexed takes a constant
          if (cur_mode == OAG_MODE_REG) begin
            ea_nxt = reg_addr;
            state_nxt = OAG_RDONE;
          end else if (cur_mode == OAG_MODE_IDX) begin
            state_nxt = OAG_CONST;
          end else begin
            state_nxt = OAG_RREG;
          end
        end
        OAG_CONST: begin
          pc_nxt = pc_r + OAG_WORD_STEP;
          if (is_li) begin
            // Immediate value goes to the register named in the opcode
            tmp_nxt = rd;
            ea_nxt = reg_addr;
            state_nxt = OAG_WDST;
          end else begin
            ea_nxt = rd;
            // Register zero as index means the constant alone
            state_nxt = (cur_reg == 4'h0) ? OAG_RDONE : OAG_RREG;
          end
        end
        OAG_RREG: begin
          if (cur_mode == OAG_MODE_IDX) begin
            ea_nxt = ea_r + rd;
            state_nxt = OAG_RDONE;
          end else begin
            ea_nxt = rd;
            state_nxt = (cur_mode == OAG_MODE_INC) ? OAG_INC : OAG_RDONE;
          end
        end
        OAG_INC: begin
          // Write-back of the bumped pointer; address already latched
          state_nxt = OAG_RDONE;
        end
        OAG_RDONE: begin
          if (is_move && !phase_r) begin
            src_ea_nxt = ea_r;
            phase_nxt = 1'b1;
            state_nxt = OAG_RES;
          end else if (is_move) begin
            state_nxt = OAG_RSRC;
          end else if (is_branch) begin
            // Through R11 this is the subroutine return
            pc_nxt = ea_r;
            state_nxt = OAG_FETCH;
          end else if (is_link) begin
            src_ea_nxt = ea_r;
            state_nxt = OAG_WLINK;
          end else begin
            src_ea_nxt = ea_r;
            state_nxt = OAG_VWP;
          end
        end
        OAG_RSRC: begin
          tmp_nxt = rd;
          state_nxt = is_byte ? OAG_RDST : OAG_WDST;
        end
        OAG_RDST: begin
          // Byte store must keep the other half of the word
          dtmp_nxt = rd;
          state_nxt = OAG_WDST;
        end
        OAG_WDST: begin
          st_nxt[OAG_ST_ZERO_BIT] = is_byte ? (src_byte == 8'h00)
                                            : (tmp_r == 16'h0000);
          state_nxt = OAG_FETCH;
        end
        OAG_WLINK: begin
          // Return address stored, no stack used
          pc_nxt = src_ea_r;
          state_nxt = OAG_FETCH;
        end
        OAG_VWP: begin
          nwp_nxt = rd;
          state_nxt = OAG_VPC;
        end
        OAG_VPC: begin
          npc_nxt = rd;
          state_nxt = OAG_SV13;
        end
        OAG_SV13: begin
          state_nxt = OAG_SV14;
        end
        OAG_SV14: begin
          state_nxt = OAG_SV15;
        end
        OAG_SV15: begin
          if (is_trap) begin
            state_nxt = OAG_SV11;
          end else begin
            // Switch only after the old context is saved
            wp_nxt = nwp_r;
            pc_nxt = npc_r;
            state_nxt = OAG_FETCH;
          end
        end
        OAG_SV11: begin
          wp_nxt = nwp_r;
          pc_nxt = npc_r;
          state_nxt = OAG_FETCH;
        end
        default: begin
          state_nxt = OAG_FETCH;
        end
      endcase
    end
  end

  // Architectural and scratch registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= OAG_FETCH;
      pc_r <= OAG_RESET_PC;
      wp_r <= OAG_RESET_WP;
      st_r <= OAG_RESET_ST;
      ir_r <= 16'h0000;
      ea_r <= 16'h0000;
      src_ea_r <= 16'h0000;
      tmp_r <= 16'h0000;
      dtmp_r <= 16'h0000;
      nwp_r <= 16'h0000;
      npc_r <= 16'h0000;
      phase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      wp_r <= wp_nxt;
      st_r <= st_nxt;
      ir_r <= ir_nxt;
      ea_r <= ea_nxt;
      src_ea_r <= src_ea_nxt;
      tmp_r <= tmp_nxt;
      dtmp_r <= dtmp_nxt;
      nwp_r <= nwp_nxt;
      npc_r <= npc_nxt;
      phase_r <= phase_nxt;
    end
  end

  // Memory request: launched one cycle after entering an access state,
  // dropped on the ack edge; costs a cycle but keeps outputs registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 15'h0000;
      wdata_r <= 16'h0000;
    end else if (req_r && mem_ack) begin
      req_r <= 1'b0;
      we_r <= 1'b0;
    end else if (acc && !req_r) begin
      req_r <= 1'b1;
      we_r <= acc_we;
      addr_r <= acc_addr[15:1];
      wdata_r <= acc_wdata;
    end
  end

  // Outputs straight from flops
  assign mem_req = req_r;
  assign mem_we = we_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign pc_out = pc_r;
  assign wp_out = wp_r;
  assign st_out = st_r;

endmodule // oag_core

//--- src/oag_pkg.sv
// Purpose: Shared constants for the operand address generation block.
// Assumes: Word-wide memory, big-endian bytes, one clock domain.
// Notes: Opcode encodings below are local to this block.
//
// What this block does
// - Only program counter, status, workspace pointer held.
// - Register x lives at workspace plus 2x.
// - Full-word accesses only; byte picked inside.
// - Words are even; instructions fetched consecutively.
// - Immediate operand is the following word.
// - Indirect mode: register value is operand address.
// - Auto-increment adds one for bytes, two words.
// - Indexed adds constant and register; R0 means none.
// - Jump target is next address plus twice displacement.
// - Source constant word first, destination constant next.
// - Instructions one to three words; fetch needed constants.
// - Register-register, register-memory, memory-memory moves allowed.
// - Call with link saves return in register eleven.
// - Branch through register loads its contents to PC.
// - Workspace switch call loads new workspace first.
// - Old workspace pointer saved in new register thirteen.
// - Byte access to a register uses left byte.
// - Trap uses vector table, operand address in R11.
package oag_pkg;
  // Reset values
  localparam logic [15:0] OAG_RESET_PC = 16'h0000;
  localparam logic [15:0] OAG_RESET_WP = 16'h0000;
  localparam logic [15:0] OAG_RESET_ST = 16'h0000;
  // Word step and register byte offsets inside a workspace
  localparam logic [15:0] OAG_WORD_STEP = 16'h0002;
  localparam logic [15:0] OAG_BYTE_STEP = 16'h0001;
  localparam logic [15:0] OAG_OFS_LINK = 16'h0016;
  localparam logic [15:0] OAG_OFS_OLD_WP = 16'h001A;
  localparam logic [15:0] OAG_OFS_OLD_PC = 16'h001C;
  localparam logic [15:0] OAG_OFS_OLD_ST = 16'h001E;
  // Base of the trap vector table, four bytes per entry
  localparam logic [15:0] OAG_TRAP_VEC_BASE = 16'h0040;
  // Status bit set when a moved value is zero
  localparam int OAG_ST_ZERO_BIT = 13;
  // Operand addressing modes
  localparam logic [1:0] OAG_MODE_REG = 2'h0;
  localparam logic [1:0] OAG_MODE_IND = 2'h1;
  localparam logic [1:0] OAG_MODE_IDX = 2'h2;
  localparam logic [1:0] OAG_MODE_INC = 2'h3;
  // Opcode fields
  localparam logic [3:0] OAG_OP_WORD_MOVE = 4'hC;
  localparam logic [3:0] OAG_OP_BYTE_MOVE = 4'hD;
  localparam logic [9:0] OAG_OP_BRANCH = 10'h011;
  localparam logic [9:0] OAG_OP_CALL_WITH_LINK = 10'h01A;
  localparam logic [9:0] OAG_OP_WORKSPACE_SWITCH_CALL = 10'h010;
  localparam logic [5:0] OAG_OP_EXTENDED_OPERATION_TRAP = 6'h0B;
  localparam logic [7:0] OAG_OP_RELATIVE_JUMP = 8'h10;
  localparam logic [11:0] OAG_OP_LOAD_IMMEDIATE = 12'h020;
  // Sequencer states, one-hot
  typedef enum logic [16:0] {
    OAG_FETCH  = 17'h00001,
    OAG_DECODE = 17'h00002,
    OAG_RES    = 17'h00004,
    OAG_CONST  = 17'h00008,
    OAG_RREG   = 17'h00010,
    OAG_INC    = 17'h00020,
    OAG_RDONE  = 17'h00040,
    OAG_RSRC   = 17'h00080,
    OAG_RDST   = 17'h00100,
    OAG_WDST   = 17'h00200,
    OAG_WLINK  = 17'h00400,
    OAG_VWP    = 17'h00800,
    OAG_VPC    = 17'h01000,
    OAG_SV13   = 17'h02000,
    OAG_SV14   = 17'h04000,
    OAG_SV15   = 17'h08000,
    OAG_SV11   = 17'h10000
  } oag_state_e;
endpackage
